//--- include/wdn_pkg.sv
// package: register map, field positions and timing constants of the watchdog
package wdn_pkg;
  // register bus geometry
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam logic [15:0] CTRL_ADDR     = 16'hff40;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'hff41;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hff42;
  localparam logic [15:0] COUNT_ADDR    = 16'hff43;
  // control register fields
  localparam int          RUN_BIT       = 0;
  localparam int          TMRST_BIT     = 1;
  localparam int          RESTART_BIT   = 2;
  localparam int          FOUTON_BIT    = 3;
  localparam int          FSEL_LSB      = 4;
  localparam int          FSEL_MSB      = 6;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RW_MASK  = 8'h79;
  // interrupt status bits
  localparam int          EV_TIMEOUT    = 0;
  localparam int          EV_SLEEP_ERR  = 1;
  localparam int          NUM_EV        = 2;
  // clocks and timing
  localparam longint      CLK_HZ        = 40000000;
  localparam longint      LOSC_HZ_X1000 = 32768000;
  localparam int          LOSC_DIV      = int'((CLK_HZ * 1000) / LOSC_HZ_X1000);
  // timeout of 3.5 s nominal: 2^17 ticks of the low oscillator is 4 s
  localparam int          TMO_TICKS     = 114688;
  localparam int          CNT_W         = 17;
  // exception vector and priority of the request
  localparam logic [23:0] NMI_VECTOR    = 24'h000004;
  localparam logic [2:0]  NMI_LEVEL     = 3'h4;
  // sleep guard after a request, 2 ms in low-oscillator ticks
  localparam int          GUARD_US      = 2000;
  localparam int          GUARD_TICKS   = (GUARD_US * 32768 + 999999) / 1000000;
endpackage

//--- include/wdn_tick_if.sv
// interface: low-oscillator tick and its gating between divider and counter
`timescale 1ns/1ps
interface wdn_tick_if;
  logic tick;
  logic stop;
  modport src (output tick, input stop);
  modport dst (input tick, output stop);
endinterface

//--- rtl/wdn_tick_div.sv
// module: divider making the low-oscillator enable pulse from clk
`timescale 1ns/1ps
module wdn_tick_div #(
  parameter int DIV = 1221
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // tick out
  wdn_tick_if.src   tk
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_r;

  // refuse a divider too small to make a one-cycle pulse
  if (DIV < 2) begin : g_bad_div
    $error("divider must be at least 2");
  end

  // divider held at zero while stopped so the oscillator is truly halted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (tk.stop) begin
      cnt_r <= '0;
    end else if (cnt_r == W'(DIV - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign tk.tick = !tk.stop && (cnt_r == W'(DIV - 1));
endmodule

//--- rtl/wdn_timeout_cnt.sv
// module: watchdog counter clocked by low-oscillator ticks
`timescale 1ns/1ps
module wdn_timeout_cnt #(
  parameter int LIMIT = 114688,
  parameter int W     = 17
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // tick and control
  wdn_tick_if.dst           tk,
  input  wire logic         sleep,
  input  wire logic         restart,
  // state
  output logic [W-1:0]      count,
  output logic              expire
);
  // refuse a limit the counter width cannot reach
  if (LIMIT < 2 || LIMIT > (1 << W)) begin : g_bad_limit
    $error("limit does not fit counter");
  end

  assign tk.stop = sleep;
  assign expire  = tk.tick && (count == W'(LIMIT - 1));

  // restart wins over a tick; wraps to zero after expiry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (tk.tick) begin
      count <= expire ? '0 : count + 1'b1;
    end
  end
endmodule

//--- rtl/wdn_watchdog.sv
// module: watchdog with nmi request and control register
// Behaviour
// - counter runs only on low-oscillator ticks
// - no restart for timeout raises nmi
// - counting continues while cpu halted
// - sleep stops counting and requests
// - request goes to nmi input, level 4
// - request cannot be masked, top priority
// - exception vector is 000004h
// - writing one to restart clears counter
// - writing zero to restart does nothing
// - restart bit always reads zero
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module wdn_watchdog #(
  parameter int TMO_TICKS = wdn_pkg::TMO_TICKS,
  parameter int LOSC_DIV  = wdn_pkg::LOSC_DIV
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [wdn_pkg::ADDR_W-1:0] addr,
  input  wire logic [wdn_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [wdn_pkg::DATA_W-1:0]      rdata,
  // cpu state
  input  wire logic                       cpu_halt,
  input  wire logic                       cpu_sleep,
  // nmi toward the cpu
  output logic                            nmi_req,
  output logic                            nmi_n,
  output logic [2:0]                      nmi_level,
  output logic [23:0]                     nmi_vector,
  input  wire logic                       nmi_ack,
  // maskable event interrupt
  output logic                            irq
);
  import wdn_pkg::*;

  // refuse settings the counter or divider cannot serve
  if (TMO_TICKS < 2 || TMO_TICKS > (1 << CNT_W)) begin : g_bad_tmo
    $error("bad timeout");
  end
  if (LOSC_DIV < 2) begin : g_bad_div
    $error("bad divider");
  end

  wdn_tick_if tk ();

  logic [7:0]        ctrl_r;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] mask_r;
  logic              nmi_r;
  logic [7:0]        rdata_r;
  logic [CNT_W-1:0]  count;
  logic              expire;
  logic              restart;
  logic [7:0]        guard_r;
  logic              wr_ctrl;

  assign wr_ctrl = wr && (addr == CTRL_ADDR);
  // only a one restarts; zero is no operation
  assign restart = wr_ctrl && wdata[RESTART_BIT];

  wdn_tick_div #(
    .DIV (LOSC_DIV)
  ) u_div (
    .clk (clk),
    .rst (rst),
    .tk  (tk.src)
  );

  // halt is not an input to the counter: it keeps running
  wdn_timeout_cnt #(
    .LIMIT (TMO_TICKS),
    .W     (CNT_W)
  ) u_cnt (
    .clk     (clk),
    .rst     (rst),
    .tk      (tk.dst),
    .sleep   (cpu_sleep),
    .restart (restart),
    .count   (count),
    .expire  (expire)
  );

  // control register, write-only bits never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata & CTRL_RW_MASK;
    end
  end

  // nmi pending until the cpu takes it; not gated by any mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_r <= 1'b0;
    end else if (expire) begin
      nmi_r <= 1'b1;
    end else if (nmi_ack) begin
      nmi_r <= 1'b0;
    end
  end

  assign nmi_req    = nmi_r;
  assign nmi_n      = !nmi_r;
  assign nmi_level  = NMI_LEVEL;
  assign nmi_vector = NMI_VECTOR;

  // guard window after a request to flag an early sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_r <= '0;
    end else if (expire) begin
      guard_r <= 8'(GUARD_TICKS);
    end else if (tk.tick && guard_r != 8'h00) begin
      guard_r <= guard_r - 8'h01;
    end
  end

  // sticky events, set beats a write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      for (int i = 0; i < NUM_EV; i++) begin
        if (wr && addr == IRQ_STAT_ADDR && wdata[i]) stat_r[i] <= 1'b0;
      end
      if (expire) stat_r[EV_TIMEOUT] <= 1'b1;
      if (cpu_sleep && guard_r != 8'h00) stat_r[EV_SLEEP_ERR] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wr && addr == IRQ_MASK_ADDR) begin
      mask_r <= wdata[NUM_EV-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (rd) begin
      if (addr == CTRL_ADDR) begin
        rdata_r <= ctrl_r;
      end else if (addr == IRQ_STAT_ADDR) begin
        rdata_r <= {{(8-NUM_EV){1'b0}}, stat_r};
      end else if (addr == IRQ_MASK_ADDR) begin
        rdata_r <= {{(8-NUM_EV){1'b0}}, mask_r};
      end else if (addr == COUNT_ADDR) begin
        rdata_r <= count[CNT_W-1:CNT_W-8];
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;
endmodule

//--- verif/wdn_watchdog_sva.sv
// checker: port-level assertions of the watchdog
`timescale 1ns/1ps
module wdn_watchdog_sva #(
  parameter int TMO_TICKS = 8,
  parameter int LOSC_DIV  = 4
) (
  // clock, reset and register port
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [wdn_pkg::ADDR_W-1:0] addr,
  input wire logic [wdn_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [wdn_pkg::DATA_W-1:0] rdata,
  // cpu side
  input wire logic                       cpu_sleep,
  input wire logic                       nmi_req,
  input wire logic                       nmi_n,
  input wire logic [2:0]                 nmi_level,
  input wire logic [23:0]                nmi_vector,
  input wire logic                       nmi_ack
);
  import wdn_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // restart command seen on the register port
  sequence restart_s;
    wr && addr == CTRL_ADDR && wdata[RESTART_BIT];
  endsequence
  nmi_polarity_a: assert property (nmi_n == !nmi_req)
    else $error("nmi_n not inverse of nmi_req");
  nmi_level_a: assert property (nmi_level == NMI_LEVEL)
    else $error("nmi level wrong");
  nmi_vector_a: assert property (nmi_vector == NMI_VECTOR)
    else $error("nmi vector wrong");
  idle_read_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without read");
  restart_reads_a: assert property (rd && addr == CTRL_ADDR |=> !rdata[RESTART_BIT])
    else $error("restart bit read as one");
  sleep_hold_a: assert property (cpu_sleep [*3] |-> !$rose(nmi_req))
    else $error("nmi raised in sleep");
  restart_quiet_a: assert property (restart_s |-> ##2 !$rose(nmi_req) [*8])
    else $error("nmi soon after restart");
  nmi_stands_a: assert property (nmi_req && !nmi_ack |=> nmi_req)
    else $error("nmi dropped without ack");
endmodule
bind wdn_watchdog wdn_watchdog_sva #(.TMO_TICKS(TMO_TICKS), .LOSC_DIV(LOSC_DIV)) chk_i (
  .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cpu_sleep,
  .nmi_req, .nmi_n, .nmi_level, .nmi_vector, .nmi_ack);

//--- verif/wdn_cpu_model.sv
// model: cpu core taking the nmi after a set delay
`timescale 1ns/1ps
module wdn_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // nmi handshake
  input  wire logic       nmi_req,
  input  wire logic [3:0] ack_dly,
  output logic            nmi_ack,
  output int              taken
);
  int wait_c;
  // a pending request is always taken, never masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_ack <= 1'b0;
      wait_c <= 0;
      taken <= 0;
    end else begin
      nmi_ack <= 1'b0;
      if (nmi_req && !nmi_ack) begin
        wait_c <= wait_c + 1;
        if (wait_c >= ack_dly) begin
          nmi_ack <= 1'b1;
          taken <= taken + 1;
          wait_c <= 0;
        end
      end
    end
  end
endmodule

//--- verif/tb_top.sv
// testbench: register, timeout, sleep and repeat checks of the watchdog
`timescale 1ns/1ps
module tb_top;
  import wdn_pkg::*;
  localparam int TMO = 8;
  localparam int DIV = 4;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cpu_halt = 0, cpu_sleep = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [3:0]  ack_dly = 4'h2;
  logic        nmi_req, nmi_n, nmi_ack, irq;
  logic [2:0]  nmi_level;
  logic [23:0] nmi_vector;
  int          bad_count = 0, checked = 0, cyc = 0, taken, t0, i;
  int          seed = 32'hc30dc457, mdl;
  always #12.5 clk = ~clk;
  wdn_watchdog #(.TMO_TICKS(TMO), .LOSC_DIV(DIV)) wdn_watchdog_i (.clk, .rst, .addr, .wdata,
    .wr, .rd, .rdata, .cpu_halt, .cpu_sleep, .nmi_req, .nmi_n, .nmi_level, .nmi_vector,
    .nmi_ack, .irq);
  wdn_cpu_model wdn_cpu_model_i (.clk, .rst, .nmi_req, .ack_dly, .nmi_ack, .taken);
  task chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    #1;  // a following write raises wr in a later time step
  endtask
  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // watch for a request over lim cycles
  task wait_nmi(input int lim, input logic e);
    logic g;
    g = 0;
    for (int k = 0; k < lim && !g; k++) begin
      @(posedge clk) #1;
      if (nmi_req === 1'b1) g = 1;
    end
    chk("nmi_req", g, e);
  endtask
  task complete_run;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(CTRL_ADDR, CTRL_RESET);
    for (i = 0; i < 4; i++) begin
      mdl = $random(seed);
      wr_reg(CTRL_ADDR, mdl[7:0]);
      rd_chk(CTRL_ADDR, mdl[7:0] & CTRL_RW_MASK);
    end
    rd_chk(16'hff44, 8'h00);
    rd_chk(COUNT_ADDR, 8'h00);  // count stays far below 512 ticks here
    ack_dly <= 4'($random(seed));
    $display("register test done");
    for (i = 0; i < 6; i++) begin
      wr_reg(CTRL_ADDR, 8'h04);
      wait_nmi(16, 1'b0);
    end
    $display("restart test done");
    cpu_sleep <= 1'b1;
    wait_nmi(100, 1'b0);
    cpu_sleep <= 1'b0;
    wait_nmi(60, 1'b1);
    chk("nmi_n", nmi_n, 1'b0);
    chk("nmi_level", nmi_level, 3'h4);
    chk("nmi_vector", nmi_vector, 24'h000004);
    $display("sleep test done");
    wr_reg(CTRL_ADDR, 8'h04);
    // no sleep entered after the request, so only the timeout bit is set
    rd_chk(IRQ_STAT_ADDR, 8'h01);
    #1 chk("irq", irq, 1'b0);
    wr_reg(IRQ_MASK_ADDR, 8'h01);
    #1 chk("irq", irq, 1'b1);
    rd_chk(IRQ_MASK_ADDR, 8'h01);
    wr_reg(IRQ_STAT_ADDR, 8'h01);
    rd_chk(IRQ_STAT_ADDR, 8'h00);
    $display("status test done");
    cpu_halt <= 1'b1;
    wr_reg(CTRL_ADDR, 8'h04);
    wr_reg(CTRL_ADDR, 8'hfb);
    // let the earlier request be taken before the window opens
    repeat (19) @(posedge clk);
    #1 t0 = taken;
    // zero writes to the restart bit must not hold off the repeats
    for (i = 0; i < 104; i++) wr_reg(CTRL_ADDR, 8'hfb);
    chk("repeats", taken - t0, 104 / (TMO * DIV));
    $display("halt test done");
    complete_run();
  end
endmodule
